// ---- verilog/dbg_pkg.sv ----
// Function
// - A-only mode: trigger when bus address equals comparator A.
// - A-or-B mode: trigger when address equals comparator A or B.
// - A-then-B mode: B match triggers only after an earlier A match.
// - A-and-B-data: A address, B low byte data, optional direction, one cycle.
// - A-and-not-B-data: A address, data differs from B low byte, optional direction.
// - tag break in full modes ignores data match, fires on A address.
// - event-only-B: each B match captures data; run ends when FIFO full.
// - A-then-event-B: after A, each B match captures data until FIFO full.
// - inside range: trigger when A <= address <= B.
// - outside range: trigger when address < A or address > B.
// - wait/stop status reads 1 in wait/stop or after forced halt from it.
// - access failure bit set when memory command collides with wait/stop.
// - slow-access failure bit always reads 0.
// - break address register reached only by dedicated serial commands.
// - break enable and force/tag select bits configure hardware breakpoint.
// - force-reset register accepts serial writes only, user writes ignored.
// - force-reset register always reads 0x00.
package dbg_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] MODE_A_ONLY = 4'h0;
    localparam logic [3:0] MODE_A_OR_B = 4'h1;
    localparam logic [3:0] MODE_A_THEN_B = 4'h2;
    localparam logic [3:0] MODE_EVT_B = 4'h3;
    localparam logic [3:0] MODE_A_THEN_EVT_B = 4'h4;
    localparam logic [3:0] MODE_A_AND_B_DATA = 4'h5;
    localparam logic [3:0] MODE_A_AND_NB_DATA = 4'h6;
    localparam logic [3:0] MODE_INSIDE = 4'h7;
    localparam logic [3:0] MODE_OUTSIDE = 4'h8;
    // status/control bit positions
    localparam int SC_HALT_ACTIVE = 6;
    localparam int SC_HW_BREAK_EN = 4;
    localparam int SC_FORCE_MARK = 3;
    localparam int SC_WAIT_STOP = 2;
    localparam int SC_LP_FAIL = 1;
    localparam int SC_SLOW_FAIL = 0;
    localparam int FR_RESET_BIT = 0;
    localparam logic [7:0] SC_RESET = 8'h00;
    localparam logic [7:0] FR_READ_VALUE = 8'h00;
    localparam logic [15:0] BKPT_RESET = 16'h0000;
    localparam logic [15:0] CMP_RESET = 16'h0000;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic rnw;
    } bus_cycle_t;

    typedef struct packed {
        logic [3:0] mode;
        logic dirMatchValue;
        logic dirMatchEnable;
        logic cpuBreakEnable;
        logic tagSelect;
    } trig_cfg_t;
endpackage : dbg_pkg

// ---- verilog/dbg_capture_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module dbg_capture_fifo
    import dbg_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int WIDTH = DATA_W
) (
    // clock and control
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic flush,
    // write side
    input wire logic wrEn,
    input wire logic [WIDTH-1:0] wrData,
    // read side
    input wire logic rdEn,
    output logic [WIDTH-1:0] rdData,
    output logic full,
    output logic empty
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_ff;
    logic [PW-1:0] rdPtr_ff;
    logic [PW:0] count_ff;
    logic doWr;
    logic doRd;

    assign doWr = wrEn && !full;
    assign doRd = rdEn && !empty;
    assign full = count_ff == (PW+1)'(DEPTH);
    assign empty = count_ff == '0;
    assign rdData = mem[rdPtr_ff];

    always_ff @(posedge mclk) begin
        if (clkEn && doWr) begin
            mem[wrPtr_ff] <= wrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || (clkEn && flush)) begin
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
        end else if (clkEn) begin
            if (doWr) begin
                wrPtr_ff <= (wrPtr_ff == PW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
            end
            if (doRd) begin
                rdPtr_ff <= (rdPtr_ff == PW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
            end
            count_ff <= count_ff + (PW+1)'(doWr) - (PW+1)'(doRd);
        end
    end
endmodule : dbg_capture_fifo
`default_nettype wire

// ---- verilog/debug_trigger_and_bdc_status.sv ----
`timescale 1ns/1ps
`default_nettype none
module debug_trigger_and_bdc_status
    import dbg_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clkEn,
    // observed cpu bus cycle
    input wire bus_cycle_t busCycle,
    // trigger configuration and comparators
    input wire trig_cfg_t trigCfg,
    input wire logic [ADDR_W-1:0] compA,
    input wire logic [ADDR_W-1:0] compB,
    input wire logic armRun,
    // cpu power state and background events
    input wire logic cpuWaitStop,
    input wire logic haltCmd,
    input wire logic resumeCmd,
    input wire logic memCmdActive,
    // serial background register access
    input wire logic serWrScEn,
    input wire logic [7:0] serWrScData,
    input wire logic breakAddrLoad,
    input wire logic [15:0] breakAddrData,
    input wire logic serWrFrEn,
    input wire logic [7:0] serWrFrData,
    // user program write attempt to force-reset register
    input wire logic userWrFrEn,
    // fifo drain
    input wire logic fifoRdEn,
    // outputs
    output logic trigger,
    output logic tagRequest,
    output logic forceBreak,
    output logic runActive,
    output logic fifoFull,
    output logic [DATA_W-1:0] fifoRdData,
    output logic [7:0] statusCtrl,
    output logic [15:0] breakAddrQuery,
    output logic [7:0] forceResetRead,
    output logic targetReset
);
    typedef enum logic [1:0] {
        ARM_IDLE = 2'b01,
        ARM_SEEN_A = 2'b10
    } arm_state_t;

    arm_state_t armState_ff;
    arm_state_t nxt_armState;
    logic runActive_ff;
    logic trigger_ff;
    logic tagRequest_ff;
    logic forceBreak_ff;
    logic [7:0] ctrl_ff;
    logic haltActive_ff;
    logic wsForced_ff;
    logic lpFail_ff;
    logic [15:0] breakAddr_ff;
    logic targetReset_ff;
    logic fifoFull_ff;
    logic [DATA_W-1:0] fifoRdData_ff;
    logic [7:0] statusCtrl_ff;

    logic matchA;
    logic matchB;
    logic dataEq;
    logic dirOk;
    logic capture;
    logic hit;
    logic fifoFullRaw;
    logic [DATA_W-1:0] fifoDataRaw;
    logic fullMode;
    logic waitStopStatus;
    logic bkptHit;

    assign matchA = busCycle.valid && busCycle.addr == compA;
    assign matchB = busCycle.valid && busCycle.addr == compB;
    assign dataEq = busCycle.data == compB[DATA_W-1:0];
    assign dirOk = !trigCfg.dirMatchEnable || busCycle.rnw == trigCfg.dirMatchValue;
    assign fullMode = trigCfg.mode == MODE_A_AND_B_DATA || trigCfg.mode == MODE_A_AND_NB_DATA;

    always_comb begin
        nxt_armState = armState_ff;
        hit = 1'b0;
        capture = 1'b0;
        case (trigCfg.mode)
            MODE_A_ONLY: hit = matchA;
            MODE_A_OR_B: hit = matchA || matchB;
            MODE_A_THEN_B: begin
                if (armState_ff == ARM_SEEN_A) begin
                    hit = matchB;
                end else if (matchA) begin
                    nxt_armState = ARM_SEEN_A;
                end
            end
            MODE_A_AND_B_DATA: hit = matchA && dataEq && dirOk;
            MODE_A_AND_NB_DATA: hit = matchA && !dataEq && dirOk;
            MODE_EVT_B: capture = matchB;
            MODE_A_THEN_EVT_B: begin
                if (armState_ff == ARM_SEEN_A) begin
                    capture = matchB;
                end else if (matchA) begin
                    nxt_armState = ARM_SEEN_A;
                end
            end
            MODE_INSIDE: begin
                hit = busCycle.valid && busCycle.addr >= compA && busCycle.addr <= compB;
            end
            MODE_OUTSIDE: begin
                hit = busCycle.valid && (busCycle.addr < compA || busCycle.addr > compB);
            end
            default: hit = 1'b0;
        endcase
        if (!runActive_ff) begin
            hit = 1'b0;
            capture = 1'b0;
        end
    end

    // sequence memory cleared when a run is armed so an old A match does not leak in
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            armState_ff <= ARM_IDLE;
        end else if (clkEn) begin
            armState_ff <= armRun ? ARM_IDLE : (runActive_ff ? nxt_armState : armState_ff);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            runActive_ff <= 1'b0;
        end else if (clkEn) begin
            if (armRun) begin
                runActive_ff <= 1'b1;
            end else if (fifoFullRaw && (trigCfg.mode == MODE_EVT_B
                                         || trigCfg.mode == MODE_A_THEN_EVT_B)) begin
                runActive_ff <= 1'b0;
            end
        end
    end

    dbg_capture_fifo #(
        .DEPTH(FIFO_DEPTH),
        .WIDTH(DATA_W)
    ) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .flush(armRun),
        .wrEn(capture),
        .wrData(busCycle.data),
        .rdEn(fifoRdEn),
        .rdData(fifoDataRaw),
        .full(fifoFullRaw),
        .empty()
    );

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            trigger_ff <= 1'b0;
            tagRequest_ff <= 1'b0;
            forceBreak_ff <= 1'b0;
        end else if (clkEn) begin
            trigger_ff <= hit || capture;
            // tag request in full modes ignores the data compare
            tagRequest_ff <= (trigCfg.cpuBreakEnable && trigCfg.tagSelect
                && runActive_ff && (fullMode ? matchA : hit))
                || (bkptHit && ctrl_ff[SC_FORCE_MARK]);
            forceBreak_ff <= (trigCfg.cpuBreakEnable && !trigCfg.tagSelect && hit)
                || (bkptHit && !ctrl_ff[SC_FORCE_MARK]);
        end
    end

    // control bits written by serial commands; status bits are hardware owned
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_ff <= SC_RESET;
        end else if (clkEn && serWrScEn) begin
            ctrl_ff <= serWrScData;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            haltActive_ff <= 1'b0;
            wsForced_ff <= 1'b0;
        end else if (clkEn) begin
            if (haltCmd) begin
                haltActive_ff <= 1'b1;
                wsForced_ff <= cpuWaitStop || wsForced_ff;
            end else if (resumeCmd) begin
                haltActive_ff <= 1'b0;
                wsForced_ff <= 1'b0;
            end
        end
    end

    assign waitStopStatus = cpuWaitStop || wsForced_ff;

    // set beats clear: a new collision in the clearing cycle still shows
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lpFail_ff <= 1'b0;
        end else if (clkEn) begin
            if (memCmdActive && cpuWaitStop) begin
                lpFail_ff <= 1'b1;
            end else if (memCmdActive || haltCmd) begin
                lpFail_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            breakAddr_ff <= BKPT_RESET;
        end else if (clkEn && breakAddrLoad) begin
            breakAddr_ff <= breakAddrData;
        end
    end

    // hardware breakpoint on the break address register
    assign bkptHit = ctrl_ff[SC_HW_BREAK_EN] && busCycle.valid
        && busCycle.addr == breakAddr_ff;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            statusCtrl_ff <= SC_RESET;
            fifoFull_ff <= 1'b0;
            fifoRdData_ff <= '0;
        end else if (clkEn) begin
            statusCtrl_ff <= {ctrl_ff[7], haltActive_ff, ctrl_ff[5],
                              ctrl_ff[SC_HW_BREAK_EN], ctrl_ff[SC_FORCE_MARK],
                              waitStopStatus, lpFail_ff, 1'b0};
            fifoFull_ff <= fifoFullRaw;
            fifoRdData_ff <= fifoDataRaw;
        end
    end

    // user writes never reach this; only the serial path can pulse reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            targetReset_ff <= 1'b0;
        end else if (clkEn) begin
            targetReset_ff <= serWrFrEn && serWrFrData[FR_RESET_BIT];
        end
    end

    assign trigger = trigger_ff;
    assign tagRequest = tagRequest_ff;
    assign forceBreak = forceBreak_ff;
    assign runActive = runActive_ff;
    assign fifoFull = fifoFull_ff;
    assign fifoRdData = fifoRdData_ff;
    assign statusCtrl = statusCtrl_ff;
    assign breakAddrQuery = breakAddr_ff;
    assign forceResetRead = FR_READ_VALUE;
    assign targetReset = targetReset_ff;

    chk_a_only_hit: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && runActive_ff && trigCfg.mode == MODE_A_ONLY && matchA |=> trigger)
        else $error("a-only match gave no trigger");
    chk_or_hit: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && runActive_ff && trigCfg.mode == MODE_A_OR_B && (matchA || matchB) |=> trigger)
        else $error("a-or-b match gave no trigger");
    chk_then_b_needs_a: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && trigCfg.mode == MODE_A_THEN_B && armState_ff == ARM_IDLE |=> !trigger)
        else $error("b triggered before a");
    chk_data_mode: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && runActive_ff && trigCfg.mode == MODE_A_AND_B_DATA && matchA && !dataEq
        |=> !trigger)
        else $error("data mismatch triggered");
    chk_not_data: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && runActive_ff && trigCfg.mode == MODE_A_AND_NB_DATA && matchA && dataEq
        |=> !trigger)
        else $error("equal data triggered in not mode");
    chk_tag_full: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && runActive_ff && fullMode && matchA && trigCfg.cpuBreakEnable
        && trigCfg.tagSelect |=> tagRequest)
        else $error("tag missing on a match");
    chk_run_ends: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && !armRun && fifoFullRaw && trigCfg.mode == MODE_EVT_B |=> !runActive)
        else $error("run did not end on full fifo");
    chk_inside_rng: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && runActive_ff && trigCfg.mode == MODE_INSIDE && busCycle.valid
        && busCycle.addr < compA |=> !trigger)
        else $error("inside range fired below a");
    chk_outside_rng: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && runActive_ff && trigCfg.mode == MODE_OUTSIDE && busCycle.valid
        && busCycle.addr > compB |=> trigger)
        else $error("outside range missed above b");
    chk_lp_set: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && memCmdActive && cpuWaitStop |=> lpFail_ff)
        else $error("access failure not flagged");
    chk_break_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && bkptHit |=> tagRequest || forceBreak)
        else $error("break address hit gave no break");
    chk_slow_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        !statusCtrl[SC_SLOW_FAIL])
        else $error("slow fail bit set");
    chk_fr_reads0: assert property (@(posedge mclk) disable iff (!rst_n)
        serWrFrEn |=> forceResetRead == FR_READ_VALUE)
        else $error("force reset read nonzero");
    chk_user_wr: assert property (@(posedge mclk) disable iff (!rst_n)
        clkEn && userWrFrEn && !serWrFrEn |=> !targetReset)
        else $error("user write reset target");
    cov_then_b: cover property (@(posedge mclk) trigCfg.mode == MODE_A_THEN_B && trigger);
    cov_fifo_full: cover property (@(posedge mclk) fifoFull && !runActive);
    cov_reset: cover property (@(posedge mclk) targetReset);
endmodule : debug_trigger_and_bdc_status
`default_nettype wire

// ---- tb/debug_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module debug_host_model
    import dbg_pkg::*;
(
    // clock and status seen by the host
    input wire logic mclk,
    input wire logic [7:0] statusCtrl,
    // serial command strobes and data
    output logic haltCmd,
    output logic resumeCmd,
    output logic memCmdActive,
    output logic serWrScEn,
    output logic [7:0] serWrScData,
    output logic breakAddrLoad,
    output logic [15:0] breakAddrData,
    output logic serWrFrEn,
    output logic [7:0] serWrFrData
);
    initial begin
        {haltCmd, resumeCmd, memCmdActive, serWrScEn, breakAddrLoad, serWrFrEn} = 6'h00;
        serWrScData = 8'h5a;
        breakAddrData = 16'ha5c3;
        serWrFrData = 8'h5a;
    end

    // kind: 0 halt, 1 resume, 2 memory access, 3 control, 4 break address, 5 force reset
    // gap lets the host answer slowly
    task automatic cmd(input int kind, input logic [15:0] val, input int gap);
        repeat (gap) @(negedge mclk);
        @(negedge mclk);
        case (kind)
            0: haltCmd = 1'b1;
            1: resumeCmd = 1'b1;
            2: memCmdActive = 1'b1;
            3: begin
                serWrScEn = 1'b1;
                serWrScData = val[7:0];
            end
            4: begin
                breakAddrLoad = 1'b1;
                breakAddrData = val;
            end
            default: begin
                serWrFrEn = 1'b1;
                serWrFrData = val[7:0];
            end
        endcase
        @(negedge mclk);
        {haltCmd, resumeCmd, memCmdActive, serWrScEn, breakAddrLoad, serWrFrEn} = 6'h00;
        // released data flips so a stale byte never passes for a valid one
        serWrScData = ~serWrScData;
        breakAddrData = ~breakAddrData;
        serWrFrData = ~serWrFrData;
    endtask : cmd

    // no further command until halt is seen active or 8 cycles pass
    task automatic forceBackground(output bit ok);
        cmd(0, 16'h0000, 0);
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(negedge mclk);
            ok = statusCtrl[SC_HALT_ACTIVE] === 1'b1;
        end
    endtask : forceBackground
endmodule : debug_host_model
`default_nettype wire

// ---- tb/debug_trigger_and_bdc_status_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module debug_trigger_and_bdc_status_test import dbg_pkg::*;;
    logic mclk, rst_n, clkEn, armRun, cpuWaitStop, userWrFrEn, fifoRdEn;
    logic haltCmd, resumeCmd, memCmdActive, serWrScEn, breakAddrLoad, serWrFrEn;
    logic trigger, tagRequest, forceBreak, runActive, fifoFull, targetReset;
    logic [7:0] serWrScData, serWrFrData, statusCtrl, forceResetRead, fifoRdData;
    logic [15:0] compA, compB, breakAddrData, breakAddrQuery, a;
    logic pendTrig, pendTag, seen;
    bus_cycle_t busCycle;
    trig_cfg_t trigCfg;
    int num_errors, n_compared, seed, nCap, r;
    bit aSeen, ok, tagOn;
    logic [7:0] capQ[$];

    debug_trigger_and_bdc_status dut (.*);
    debug_host_model host (.*);

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    // one bus cycle; checks the answer to the previous one
    task automatic step(input logic v, input logic [15:0] ad, input logic [7:0] d, input logic rw);
        logic hitA, hitB, dirOk, hit, evt;
        @(negedge mclk);
        check(16'(trigger), 16'(pendTrig), "trigger");
        check(16'(tagRequest), 16'(pendTag), "tag");
        evt = trigCfg.mode == MODE_EVT_B || trigCfg.mode == MODE_A_THEN_EVT_B;
        if (evt && nCap >= FIFO_DEPTH)
            v = 1'b0;
        hitA = v && ad == compA;
        hitB = v && ad == compB;
        dirOk = !trigCfg.dirMatchEnable || rw == trigCfg.dirMatchValue;
        case (trigCfg.mode)
            MODE_A_ONLY: hit = hitA;
            MODE_A_OR_B: hit = hitA || hitB;
            MODE_A_THEN_B, MODE_A_THEN_EVT_B: hit = hitB && aSeen;
            MODE_EVT_B: hit = hitB;
            MODE_A_AND_B_DATA: hit = hitA && dirOk && d == compB[7:0];
            MODE_A_AND_NB_DATA: hit = hitA && dirOk && d != compB[7:0];
            MODE_INSIDE: hit = v && ad >= compA && ad <= compB;
            default: hit = v && (ad < compA || ad > compB);
        endcase
        if (hitA)
            aSeen = 1'b1;
        if (hit && evt) begin
            nCap++;
            capQ.push_back(d);
        end
        pendTrig = hit;
        pendTag = tagOn && hitA;
        busCycle = '{v, ad, d, rw};
    endtask : step

    // status levels settle within two cycles of their cause
    task automatic expectSc(input int idx, input logic val, input string what);
        repeat (3) @(negedge mclk);
        check(16'(statusCtrl[idx]), 16'(val), what);
    endtask : expectSc

    task automatic waitBreak(input bit tag);
        for (int i = 0; i < 6; i++) begin
            seen = tag ? tagRequest : forceBreak;
            if (seen !== 1'b1)
                @(negedge mclk);
        end
        check(16'(seen), 16'h0001, "break pulse");
        if (seen !== 1'b1)
            conclude();
    endtask : waitBreak

    always @(negedge mclk) begin
        if (rst_n === 1'b1) begin
            check(16'(statusCtrl[SC_SLOW_FAIL]), 16'h0000, "slow fail");
            check(16'(forceResetRead), 16'h0000, "fr read");
        end
    end

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    initial begin
        {num_errors, n_compared, nCap} = '0;
        seed = 32'h9fb9_9d8b;
        {rst_n, armRun, cpuWaitStop, userWrFrEn, fifoRdEn, pendTrig, pendTag} = '0;
        clkEn = 1'b1;
        {busCycle, trigCfg, tagOn, aSeen, a} = '0;
        compA = 16'h0000;
        compB = 16'hffff;
        repeat (10) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        check(16'(statusCtrl), 16'(SC_RESET), "sc reset");
        check(breakAddrQuery, BKPT_RESET, "bkpt reset");
        for (int m = 0; m < 9; m++) begin
            // settle the last cycle under the old setup before switching mode
            step(1'b0, a, 8'h00, 1'b0);
            r = $random(seed);
            compA = {1'b0, r[14:0]};
            compB = {1'b1, r[30:16]};
            tagOn = (m == 5 || m == 6) && r[15];
            trigCfg = '{4'(m), r[31], r[0] && !tagOn, tagOn, tagOn};
            armRun = 1'b1;
            aSeen = 1'b0;
            nCap = 0;
            capQ.delete();
            step(1'b0, a, 8'h00, 1'b0);
            armRun = 1'b0;
            repeat (40) begin
                r = $random(seed);
                case (r[2:0])
                    3'h0, 3'h1: a = compA;
                    3'h2, 3'h3: a = compB;
                    3'h4: a = compA - 16'h0001;
                    3'h5: a = compB + 16'h0001;
                    default: a = r[31:16];
                endcase
                step(r[3], a, r[4] ? compB[7:0] : r[15:8], r[5]);
            end
            if (m == 3 || m == 4) begin
                step(1'b1, compA, 8'h00, 1'b0);
                repeat (FIFO_DEPTH) step(1'b1, compB, 8'($random(seed)), 1'b0);
                repeat (4) step(1'b0, a, 8'h00, 1'b0);
                check(16'(runActive), 16'h0000, "run end");
                check(16'(fifoFull), 16'h0001, "full");
                foreach (capQ[i]) begin
                    check(16'(fifoRdData), 16'(capQ[i]), "fifo data");
                    fifoRdEn = 1'b1;
                    step(1'b0, a, 8'h00, 1'b0);
                    fifoRdEn = 1'b0;
                    repeat (2) step(1'b0, a, 8'h00, 1'b0);
                end
            end
        end
        step(1'b0, a, 8'h00, 1'b0);
        $display("test trigger modes done");
        {trigCfg, tagOn} = '0;
        cpuWaitStop = 1'b1;
        expectSc(SC_WAIT_STOP, 1'b1, "ws");
        host.cmd(2, 16'h0000, 0);
        expectSc(SC_LP_FAIL, 1'b1, "lp fail");
        host.forceBackground(ok);
        check(16'(ok), 16'h0001, "halt seen");
        cpuWaitStop = 1'b0;
        expectSc(SC_WAIT_STOP, 1'b1, "ws held");
        host.cmd(2, 16'h0000, 2);
        expectSc(SC_LP_FAIL, 1'b0, "lp clear");
        host.cmd(1, 16'h0000, 0);
        expectSc(SC_WAIT_STOP, 1'b0, "ws clear");
        $display("test status done");
        r = $random(seed);
        host.cmd(4, r[15:0], 32'(r[17:16]));
        repeat (2) @(negedge mclk);
        check(breakAddrQuery, r[15:0], "bkpt");
        clkEn = 1'b0;
        host.cmd(4, ~r[15:0], 0);
        clkEn = 1'b1;
        @(negedge mclk);
        check(breakAddrQuery, r[15:0], "frozen");
        for (int t = 0; t < 2; t++) begin
            host.cmd(3, t ? 16'h0018 : 16'h0010, 0);
            @(negedge mclk);
            busCycle = '{1'b1, r[15:0], 8'h00, 1'b1};
            @(negedge mclk);
            busCycle.valid = 1'b0;
            waitBreak(t[0]);
        end
        host.cmd(3, 16'h0000, 0);
        $display("test breakpoint done");
        userWrFrEn = 1'b1;
        repeat (3) begin
            @(negedge mclk);
            userWrFrEn = 1'b0;
            check(16'(targetReset), 16'h0000, "user write");
        end
        host.cmd(5, 16'h00fe, 0);
        check(16'(targetReset), 16'h0000, "no reset");
        host.cmd(5, 16'h0001, 0);
        check(16'(targetReset), 16'h0001, "reset");
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        check(breakAddrQuery, BKPT_RESET, "bkpt rereset");
        check(16'(targetReset), 16'h0000, "reset pulse");
        $display("test force reset done");
        conclude();
    end
endmodule : debug_trigger_and_bdc_status_test
`default_nettype wire
